// File: bsit_pkg.sv
// constants, types and tap states for the boundary-scan instruction block
package bsit_pkg;

    // ************************************************************
    // register sizes and codes
    // ************************************************************
    localparam int IR_LEN  = 8;
    localparam int ID_LEN  = 32;
    localparam int BSR_LEN = 113;

    localparam logic [IR_LEN-1:0] IR_EXTEST = 8'h00;
    localparam logic [IR_LEN-1:0] IR_IDCODE = 8'h21;
    localparam logic [IR_LEN-1:0] IR_BYPASS = 8'hFF;
    localparam logic [IR_LEN-1:0] IR_SAMPLE = 8'h05;
    localparam logic [IR_LEN-1:0] IR_CLAMP  = 8'h07;
    localparam logic [IR_LEN-1:0] IR_HIGHZ  = 8'h03;

    // capture-ir pattern, low two bits are 01
    localparam logic [IR_LEN-1:0] IR_CAPTURE_PAT = 8'h01;

    // identification code; value is arbitrary, bit 0 marks presence
    localparam logic [ID_LEN-1:0] ID_CODE_VAL = 32'h0ABC_DEF1;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [15:0] {
        TAP_RESET   = 16'h0001,
        TAP_IDLE    = 16'h0002,
        TAP_SEL_DR  = 16'h0004,
        TAP_CAP_DR  = 16'h0008,
        TAP_SH_DR   = 16'h0010,
        TAP_EX1_DR  = 16'h0020,
        TAP_PAU_DR  = 16'h0040,
        TAP_EX2_DR  = 16'h0080,
        TAP_UPD_DR  = 16'h0100,
        TAP_SEL_IR  = 16'h0200,
        TAP_CAP_IR  = 16'h0400,
        TAP_SH_IR   = 16'h0800,
        TAP_EX1_IR  = 16'h1000,
        TAP_PAU_IR  = 16'h2000,
        TAP_EX2_IR  = 16'h4000,
        TAP_UPD_IR  = 16'h8000
    } bsit_tap_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bsit_jtag_s;

    typedef struct packed {
        logic               tck_q;
        bsit_tap_e          tap;
        logic [IR_LEN-1:0]  ir_sh;
        logic [IR_LEN-1:0]  ir_act;
        logic [BSR_LEN-1:0] bsr_sh;
        logic [BSR_LEN-1:0] bsr_upd;
        logic [ID_LEN-1:0]  id_sh;
        logic               byp;
        logic               tdo;
        logic               tdo_oe;
    } bsit_state_s;

endpackage

// File: bsit_sync.sv
// two-stage synchroniser for signals from outside the core clock domain
`timescale 1ns/100ps
module bsit_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule

// File: bsit_tap.sv
// tap controller, instruction register and data registers of the test port
`timescale 1ns/100ps
module bsit_tap
    import bsit_pkg::*;
(
    input  wire logic               core_clk_i,
    input  wire logic               rst_n_i,
    input  wire bsit_jtag_s         jtag_i,
    output logic                    tdo_o,
    output logic                    tdo_oe_o,
    input  wire logic [BSR_LEN-1:0] ball_cap_i,
    output logic      [BSR_LEN-1:0] ball_drv_o,
    output logic                    ball_test_o,
    output logic                    ball_highz_o
);

    // ************************************************************
    // synchronisers
    // ************************************************************
    bsit_jtag_s         jtag_s;
    logic [BSR_LEN-1:0] ball_s;

    // pins arrive on the board tester's clock; two flops before any use
    bsit_sync #(.W(3)) u_sync_jtag (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .d_i        (jtag_i),
        .q_o        (jtag_s)
    );

    // balls move on their own clocks; a ball changing near capture may
    // settle either way, so only steady balls give repeatable snapshots
    bsit_sync #(.W(BSR_LEN)) u_sync_ball (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .d_i        (ball_cap_i),
        .q_o        (ball_s)
    );

    // ************************************************************
    // state
    // ************************************************************
    bsit_state_s        st_r;
    bsit_state_s        st_nxt;
    bsit_tap_e          tap_after;
    logic               tck_rise;
    logic               tck_fall;
    logic               op_extest;
    logic               op_sample;
    logic               op_clamp;
    logic               op_highz;
    logic               op_idcode;
    logic               sel_bsr;
    logic               sel_id;
    logic               sel_byp;
    logic [BSR_LEN-1:0] bsr_sin;

    // edges of the synchronised test clock; each phase needs 3 core clocks
    assign tck_rise = jtag_s.tck & ~st_r.tck_q;
    assign tck_fall = ~jtag_s.tck & st_r.tck_q;

    // ************************************************************
    // instruction decode
    // ************************************************************
    assign op_extest = (st_r.ir_act == IR_EXTEST);
    assign op_sample = (st_r.ir_act == IR_SAMPLE);
    assign op_clamp  = (st_r.ir_act == IR_CLAMP);
    assign op_highz  = (st_r.ir_act == IR_HIGHZ);
    assign op_idcode = (st_r.ir_act == IR_IDCODE);

    // data register selection follows the active code only
    assign sel_bsr = op_extest | op_sample;
    assign sel_id  = op_idcode;
    // bypass, clamp, high-z and reserved codes use the one-bit path
    assign sel_byp = ~sel_bsr & ~sel_id;

    // ************************************************************
    // boundary cells
    // ************************************************************
    // each cell shifts from its upper neighbour; the top cell takes tdi
    genvar gi;
    generate
        for (gi = 0; gi < BSR_LEN; gi++) begin : g_cell
            if (gi == BSR_LEN - 1) begin : g_top
                assign bsr_sin[gi] = jtag_s.tdi;
            end else begin : g_low
                assign bsr_sin[gi] = st_r.bsr_sh[gi+1];
            end
        end
    endgenerate

    // ************************************************************
    // tap controller
    // ************************************************************

    function automatic bsit_tap_e tap_next(bsit_tap_e t, logic m);
        bsit_tap_e n;
        n = t;
        case (t)
            TAP_RESET:  n = m ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   n = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: n = m ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: n = m ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: n = m ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
            default:    n = TAP_RESET;
        endcase
        return n;
    endfunction

    // state the controller moves to at the coming rising edge of tck
    assign tap_after = tap_next(st_r.tap, jtag_s.tms);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt       = st_r;
        st_nxt.tck_q = jtag_s.tck;
        if (tck_rise) begin
            // actions of the current state, taken on the rising edge
            case (st_r.tap)
                TAP_RESET: begin
                    st_nxt.ir_act = IR_IDCODE;
                end
                TAP_CAP_IR: begin
                    st_nxt.ir_sh = IR_CAPTURE_PAT;
                end
                TAP_SH_IR: begin
                    st_nxt.ir_sh = {jtag_s.tdi,
                                    st_r.ir_sh[IR_LEN-1:1]};
                end
                TAP_UPD_IR: begin
                    st_nxt.ir_act = st_r.ir_sh;
                end
                TAP_CAP_DR: begin
                    if (sel_bsr) begin
                        st_nxt.bsr_sh = ball_s;
                    end else if (sel_id) begin
                        st_nxt.id_sh = ID_CODE_VAL;
                    end else begin
                        st_nxt.byp = 1'b0;
                    end
                end
                TAP_SH_DR: begin
                    if (sel_bsr) begin
                        st_nxt.bsr_sh = bsr_sin;
                    end else if (sel_id) begin
                        st_nxt.id_sh = {jtag_s.tdi,
                                        st_r.id_sh[ID_LEN-1:1]};
                    end else begin
                        st_nxt.byp = jtag_s.tdi;
                    end
                end
                TAP_UPD_DR: begin
                    // preload of the held vector under sample and extest
                    if (sel_bsr) begin
                        st_nxt.bsr_upd = st_r.bsr_sh;
                    end
                end
                default: begin
                end
            endcase
            st_nxt.tap = tap_after;
            // test-logic reset makes identification active on entry
            if (tap_after == TAP_RESET) begin
                st_nxt.ir_act = IR_IDCODE;
            end
        end
        if (tck_fall) begin
            // serial out from the lsb of the selected register
            st_nxt.tdo_oe = (st_r.tap == TAP_SH_IR) ||
                            (st_r.tap == TAP_SH_DR);
            if (st_r.tap == TAP_SH_IR) begin
                st_nxt.tdo = st_r.ir_sh[0];
            end else if (sel_bsr) begin
                st_nxt.tdo = st_r.bsr_sh[0];
            end else if (sel_id) begin
                st_nxt.tdo = st_r.id_sh[0];
            end else if (sel_byp) begin
                st_nxt.tdo = st_r.byp;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r.tck_q   <= 1'b0;
            st_r.tap     <= TAP_RESET;
            st_r.ir_sh   <= IR_CAPTURE_PAT;
            st_r.ir_act  <= IR_IDCODE;
            st_r.bsr_sh  <= '0;
            st_r.bsr_upd <= '0;
            st_r.id_sh   <= '0;
            st_r.byp     <= 1'b0;
            st_r.tdo     <= 1'b0;
            st_r.tdo_oe  <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign tdo_o        = st_r.tdo;
    assign tdo_oe_o     = st_r.tdo_oe;
    assign ball_drv_o   = st_r.bsr_upd;
    assign ball_test_o  = op_extest | op_clamp;
    assign ball_highz_o = op_highz;

endmodule

// File: bsit_tap_props.sv
// port checker for the boundary-scan instruction block
`timescale 1ns/100ps
module bsit_tap_props
    import bsit_pkg::*;
(
    input wire logic               core_clk_i,
    input wire logic               rst_n_i,
    input wire bsit_jtag_s         jtag_i,
    input wire logic               tdo_o,
    input wire logic               tdo_oe_o,
    input wire logic [BSR_LEN-1:0] ball_cap_i,
    input wire logic [BSR_LEN-1:0] ball_drv_o,
    input wire logic               ball_test_o,
    input wire logic               ball_highz_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // serial output only moves in a tck low phase
    a_tdo_on_fall: assert property ($changed(tdo_o) |-> !$past(jtag_i.tck))
        else $error("tdo moved while tck high");
    a_oe_rise_low: assert property ($rose(tdo_oe_o) |-> !$past(jtag_i.tck, 2))
        else $error("tdo enable rose while tck high");
    a_oe_fall_low: assert property ($fell(tdo_oe_o) |-> !$past(jtag_i.tck))
        else $error("tdo enable fell while tck high");
    // update registers only load at a rising tck
    a_drv_on_rise: assert property ($changed(ball_drv_o) |-> $past(jtag_i.tck))
        else $error("ball vector changed while tck low");
    a_test_on_rise: assert property ($changed(ball_test_o) |-> $past(jtag_i.tck))
        else $error("test mode changed while tck low");
    a_highz_on_rise: assert property ($changed(ball_highz_o) |-> $past(jtag_i.tck))
        else $error("float mode changed while tck low");
    a_modes_apart: assert property (!(ball_test_o && ball_highz_o))
        else $error("test and float modes both active");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !tdo_oe_o && !ball_test_o && !ball_highz_o)
        else $error("outputs active after reset");
endmodule
bind bsit_tap bsit_tap_props props_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .jtag_i(jtag_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .ball_cap_i(ball_cap_i),
    .ball_drv_o(ball_drv_o), .ball_test_o(ball_test_o), .ball_highz_o(ball_highz_o));

// File: bsit_ctrl_model.sv
// board test controller model driving the scan pins
`timescale 1ns/100ps
module bsit_ctrl_model
    import bsit_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic tdo_i,
    output bsit_jtag_s jtag_o
);
    initial jtag_o = '{1'b0, 1'b1, 1'b1};
    // one tck period of 20 core clocks, tdo taken before the rise
    task automatic bit_x(input logic tms, input logic tdi, output logic tdo);
        @(posedge core_clk_i);
        jtag_o <= '{1'b0, tms, tdi};
        repeat (10) @(posedge core_clk_i);
        tdo = tdo_i;
        jtag_o.tck <= 1'b1;
        repeat (9) @(posedge core_clk_i);
    endtask
    // tck stands low and tdi returns to its pull-up level
    task automatic park();
        @(posedge core_clk_i);
        jtag_o <= '{1'b0, 1'b0, 1'b1};
    endtask
    task automatic tap_reset();
        logic d;
        repeat (5) bit_x(1'b1, 1'b1, d);
        bit_x(1'b0, 1'b1, d);
        park();
    endtask
    // from idle: scan n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n,
                        input logic [BSR_LEN-1:0] din,
                        output logic [BSR_LEN-1:0] dout);
        logic d;
        dout = '0;
        bit_x(1'b1, 1'b1, d);
        if (ir) begin
            bit_x(1'b1, 1'b1, d);
        end
        bit_x(1'b0, 1'b1, d);
        bit_x(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            bit_x(i == n - 1, din[i], dout[i]);
        end
        bit_x(1'b1, 1'b1, d);
        bit_x(1'b0, 1'b1, d);
        park();
    endtask
endmodule

// File: bsit_tap_tb.sv
// self-checking bench for the boundary-scan instruction block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH at %0t: value differs", $time); end end
module bsit_tap_tb
    import bsit_pkg::*;
;
    localparam logic [BSR_LEN-1:0] VEC = BSR_LEN'({29{4'hC}});
    logic               core_clk;
    logic               rst_n;
    bsit_jtag_s         jtag;
    logic               tdo;
    logic               tdo_oe;
    logic [BSR_LEN-1:0] ball_cap;
    logic [BSR_LEN-1:0] ball_drv;
    logic               ball_test;
    logic               ball_highz;
    logic [BSR_LEN-1:0] q;
    int                 fail_count = 0;
    int                 tests_run = 0;
    logic [7:0]         codes [5] = '{IR_CLAMP, IR_HIGHZ, IR_BYPASS,
                                      IR_CLAMP, IR_IDCODE};
    logic [1:0]         modes [5] = '{2'b10, 2'b01, 2'b00, 2'b10, 2'b00};

    bsit_tap dut_u (.core_clk_i(core_clk), .rst_n_i(rst_n), .jtag_i(jtag),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ball_cap_i(ball_cap),
        .ball_drv_o(ball_drv), .ball_test_o(ball_test), .ball_highz_o(ball_highz));
    bsit_ctrl_model ctl_u (.core_clk_i(core_clk), .tdo_i(tdo), .jtag_o(jtag));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_id();
        ctl_u.scan(1'b0, ID_LEN, '0, q);
        `CHK(q[ID_LEN-1:0], ID_CODE_VAL)
        `CHK({ball_test, ball_highz}, 2'b00)
        `CHK(tdo_oe, 1'b0)
    endtask
    task automatic t_extest();
        ctl_u.scan(1'b1, IR_LEN, BSR_LEN'(IR_SAMPLE), q);
        `CHK(q[IR_LEN-1:0], IR_CAPTURE_PAT)
        ctl_u.scan(1'b0, BSR_LEN, VEC, q);
        `CHK(q, ball_cap)
        `CHK(ball_test, 1'b0)
        ctl_u.scan(1'b1, IR_LEN, BSR_LEN'(IR_EXTEST), q);
        `CHK(ball_test, 1'b1)
        `CHK(ball_drv, VEC)
        ctl_u.scan(1'b0, BSR_LEN, ~VEC, q);
        `CHK(q, ball_cap)
        `CHK(ball_drv, ~VEC)
    endtask
    task automatic t_modes();
        for (int i = 0; i < 5; i++) begin
            ctl_u.scan(1'b1, IR_LEN, BSR_LEN'(codes[i]), q);
            `CHK({ball_test, ball_highz}, modes[i])
            ctl_u.scan(1'b0, 8, BSR_LEN'(8'hA5), q);
            if (i < 4) begin
                `CHK(q[7:0], 8'h4A)
            end else begin
                `CHK(q[7:0], ID_CODE_VAL[7:0])
            end
        end
    endtask
    task automatic t_tlr();
        ctl_u.scan(1'b1, IR_LEN, BSR_LEN'(IR_CLAMP), q);
        `CHK(ball_test, 1'b1)
        ctl_u.tap_reset();
        t_id();
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ************************************************************
    // sequence and watchdog
    // ************************************************************
    initial begin
        rst_n <= 1'b0;
        ball_cap <= BSR_LEN'({57{2'b01}});
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        ctl_u.tap_reset();
        t_id();
        t_extest();
        t_modes();
        t_tlr();
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        end_sim();
    end
endmodule
